// *** include/sbs_defs.vh ***
// constants for the stop method and brake sequencer
// assumes a 200 MHz control clock and restart-effective selectors
`ifndef SBS_DEFS_VH
`define SBS_DEFS_VH

// ----------------------------------------------------------------
// selector codes
// ----------------------------------------------------------------
`define SBS_PRI_SHORT_COAST 3'h0
`define SBS_PRI_SHORT_HOLD 3'h1
`define SBS_PRI_COAST 3'h2
`define SBS_TRV_SHORT_COAST 3'h0
`define SBS_TRV_INERTIA 3'h1
`define SBS_TRV_REV_CLAMP 3'h2
`define SBS_TRV_REV_COAST 3'h3
`define SBS_SEC_SHORT_COAST 3'h0
`define SBS_SEC_SHORT_HOLD 3'h1
`define SBS_SEC_COAST 3'h2
`define SBS_SEC_REV_SHORT 3'h3
`define SBS_SEC_REV_COAST 3'h4
`define SBS_SEC_RUN 3'h5

// ----------------------------------------------------------------
// torque limit, allocation code, timing
// ----------------------------------------------------------------
`define SBS_TORQ_MAX 9'h15e
`define SBS_TORQ_RESET 9'h12c
`define SBS_ALLOC_BRAKE 4'h4
`define SBS_TICK_MS 10
`define SBS_CLK_KHZ 200000
`define SBS_TICK_CYCLES (`SBS_TICK_MS * `SBS_CLK_KHZ)
`define SBS_BRAKE_WAIT_RESET 7'h32
`define SBS_SPEED_RESET 7'h64

`endif

// *** hw/sbs_tick_timer.v ***
// down counter in 10 ms ticks, used for both brake delays
// assumes the start pulse and the load value come from the same clock
`include "sbs_defs.vh"

module sbs_tick_timer #(
    parameter TICK_CYCLES = `SBS_TICK_CYCLES
) (
    input wire clk,
    input wire rst_b,
    input wire start,
    input wire stop,
    input wire [8:0] load,
    output reg busy,
    output reg done
);
    reg [31:0] cyc;
    reg [8:0] ticks;

    // ----------------------------------------------------------------
    // tick counter
    // ----------------------------------------------------------------
    // a zero load finishes at once, so a zero wait costs one cycle only
    always @(posedge clk) begin
        done <= 1'b0;
        if (!rst_b || stop) begin
            busy <= 1'b0;
            cyc <= 32'h0;
            ticks <= 9'h0;
        end else if (start) begin
            cyc <= 32'h0;
            ticks <= load;
            busy <= (load != 9'h0);
            done <= (load == 9'h0);
        end else if (busy) begin
            if (cyc == TICK_CYCLES - 1) begin
                cyc <= 32'h0;
                if (ticks == 9'h1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                ticks <= ticks - 9'h1;
            end else begin
                cyc <= cyc + 32'h1;
            end
        end
    end
endmodule

// *** hw/sbs_top.v ***
// stop method selection and holding brake sequencing for a servo drive
// assumes pins are asynchronous, host settings are on CLK already
//
// What this block does
// [R1] configurable stop on alarms, overtravel, servo-off
// [R2] primary selector: short-coast, short-hold, coast
// [R3] overtravel selector: short, inertia, reverse clamp/coast
// [R4] group-two selector, six choices incl. keep running
// [R5] keep-running option only warns, no stop
// [R6] reverse brake: zero speed, no ramp, torque limited
// [R7] torque limit 0..350 percent, live, default 300
// [R8] zero clamp holds position reference zero
// [R9] coast releases motor; winding short holds it
// [R10] brake output drops on servo-off or alarm
// [R11] brake routed to terminal pair coded 4
// [R12] host waits 50 ms plus release before motion
// [R13] three settings time brake and power removal
// [R14] stopped: power off after wait, brake now
// [R15] running: brake on low speed or timeout, in reverse brake only at standstill
// [R16] alarm removes power at once, except a group two reverse brake keeps it until standstill
// [R17] selectors latched at reset, unknown means default
// [R18] priority: group one, group two, overtravel, servo-off
`include "sbs_defs.vh"

module sbs_top #(
    parameter TICK_CYCLES = `SBS_TICK_CYCLES
) (
    input wire CLK,
    input wire RST_B,
    input wire SERVO_ON,
    input wire GROUP_ONE_ALARM,
    input wire GROUP_TWO_ALARM,
    input wire TRAVEL_LIMIT_STATE,
    input wire SAFETY_STATE,
    input wire [2:0] PRIMARY_STOP_SELECT,
    input wire [2:0] OVERTRAVEL_STOP_SELECT,
    input wire [2:0] SECONDARY_ALARM_STOP_SELECT,
    input wire [8:0] REVERSE_BRAKE_TORQUE_LIMIT,
    input wire [8:0] SERVO_OFF_WAIT_TIME,
    input wire [6:0] BRAKE_SPEED_THRESHOLD,
    input wire [6:0] BRAKE_WAIT_TIME,
    input wire [11:0] OUTPUT_PIN_ALLOCATION,
    input wire [15:0] MOTOR_SPEED_RPM,
    output reg MOTOR_POWER_ON,
    output reg WINDING_SHORT_HOLD,
    output reg ZERO_SPEED_FORCE,
    output reg [8:0] TORQUE_LIMIT,
    output reg ZERO_CLAMP,
    output reg ALARM_WARNING,
    output reg [2:0] BRAKE_RELEASE_OUT
);
    // state codes
    localparam ST_RUN = 3'h0;
    localparam ST_SHORT_STOP = 3'h1;
    localparam ST_COAST_STOP = 3'h2;
    localparam ST_REV_STOP = 3'h3;
    localparam ST_AFTER = 3'h4;
    localparam ST_OFF_WAIT = 3'h5;
    // after-stop codes
    localparam AF_COAST = 2'h0;
    localparam AF_SHORT = 2'h1;
    localparam AF_CLAMP = 2'h2;
    localparam AF_RUN = 2'h3;
    // stop method codes
    localparam SM_SHORT = 2'h0;
    localparam SM_COAST = 2'h1;
    localparam SM_REV = 2'h2;
    localparam SM_NONE = 2'h3;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg [4:0] sync1;
    reg [4:0] sync2;
    always @(posedge CLK) begin
        if (!RST_B) begin
            sync1 <= 5'h0;
            sync2 <= 5'h0;
        end else begin
            sync1 <= {SAFETY_STATE, TRAVEL_LIMIT_STATE, GROUP_TWO_ALARM,
                GROUP_ONE_ALARM, SERVO_ON};
            sync2 <= sync1;
        end
    end
    wire son = sync2[0];
    wire al1 = sync2[1];
    wire al2 = sync2[2];
    wire trv = sync2[3];
    wire safe = sync2[4];

    // ----------------------------------------------------------------
    // restart-effective selectors
    // ----------------------------------------------------------------
    // caught while reset is held so a live edit never changes a stop midway
    reg [2:0] sel_pri;
    reg [2:0] sel_trv;
    reg [2:0] sel_sec;
    always @(posedge CLK) begin
        if (!RST_B) begin
            sel_pri <= (PRIMARY_STOP_SELECT > `SBS_PRI_COAST) ?
                `SBS_PRI_SHORT_COAST : PRIMARY_STOP_SELECT; // [R17]
            sel_trv <= (OVERTRAVEL_STOP_SELECT > `SBS_TRV_REV_COAST) ?
                `SBS_TRV_SHORT_COAST : OVERTRAVEL_STOP_SELECT; // [R17]
            sel_sec <= (SECONDARY_ALARM_STOP_SELECT > `SBS_SEC_RUN) ?
                `SBS_SEC_SHORT_COAST : SECONDARY_ALARM_STOP_SELECT; // [R17]
        end
    end

    // ----------------------------------------------------------------
    // trigger priority and method decode
    // ----------------------------------------------------------------
    reg [1:0] method;
    reg [1:0] after;
    reg trig;
    reg is_alarm;
    // fixed trigger priority; a keep-running group two alarm only warns [R18]
    always @* begin
        trig = 1'b1;
        is_alarm = al1 || (al2 && sel_sec != `SBS_SEC_RUN); // [R16]
        method = SM_SHORT;
        after = AF_COAST;
        if (is_alarm && !al1 && !safe) begin
            case (sel_sec) // [R4]
                `SBS_SEC_SHORT_HOLD: after = AF_SHORT;
                `SBS_SEC_COAST: method = SM_COAST;
                `SBS_SEC_REV_SHORT: begin
                    method = SM_REV;
                    after = AF_SHORT;
                end
                `SBS_SEC_REV_COAST: method = SM_REV;
                default: method = SM_SHORT;
            endcase
        end else if (trv && !al1 && !safe) begin
            case (sel_trv) // [R3]
                `SBS_TRV_INERTIA: method = SM_COAST;
                `SBS_TRV_REV_CLAMP: begin
                    method = SM_REV;
                    after = AF_CLAMP;
                end
                `SBS_TRV_REV_COAST: method = SM_REV;
                default: method = SM_SHORT;
            endcase
        end else if (al1 || safe || !son) begin
            // group one, safety and servo-off share one selector [R2]
            method = (sel_pri == `SBS_PRI_COAST) ? SM_COAST : SM_SHORT;
            after = (sel_pri == `SBS_PRI_SHORT_HOLD) ? AF_SHORT : AF_COAST;
        end else begin
            trig = 1'b0;
            method = SM_NONE; // [R5]
            after = AF_RUN;
        end
    end

    // ----------------------------------------------------------------
    // brake timers
    // ----------------------------------------------------------------
    reg off_start;
    reg brk_start;
    wire off_done;
    wire brk_busy;
    wire brk_done;
    wire stopped = (MOTOR_SPEED_RPM == 16'h0);
    wire slow = (MOTOR_SPEED_RPM < {9'h0, BRAKE_SPEED_THRESHOLD});

    sbs_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_off_wait (
        .clk(CLK),
        .rst_b(RST_B),
        .start(off_start),
        .stop(son),
        .load(SERVO_OFF_WAIT_TIME), // [R14]
        .busy(),
        .done(off_done)
    );
    sbs_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_brk_wait (
        .clk(CLK),
        .rst_b(RST_B),
        .start(brk_start),
        .stop(son && !trig),
        .load({2'h0, BRAKE_WAIT_TIME}),
        .busy(brk_busy),
        .done(brk_done)
    );

    // ----------------------------------------------------------------
    // stop sequencer
    // ----------------------------------------------------------------
    reg [2:0] state;
    reg [1:0] after_hold;
    reg brake_rel;
    always @(posedge CLK) begin
        off_start <= 1'b0;
        brk_start <= 1'b0;
        if (!RST_B) begin
            state <= ST_AFTER;
            after_hold <= AF_COAST;
            brake_rel <= 1'b0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (trig) begin
                        after_hold <= after;
                        // only servo off on a still motor with no stopping alarm waits with power on, even with overtravel or safety active
                        if (is_alarm || !stopped || son) begin
                            brake_rel <= stopped ? 1'b0 : brake_rel; // [R10]
                            brk_start <= !stopped; // [R15]
                            state <= (method == SM_REV) ? ST_REV_STOP :
                                (method == SM_COAST) ? ST_COAST_STOP : ST_SHORT_STOP; // [R1]
                        end else begin
                            brake_rel <= 1'b0; // [R14]
                            off_start <= 1'b1;
                            state <= ST_OFF_WAIT;
                        end
                    end
                end
                ST_OFF_WAIT: begin
                    // servo back on stops the timer, so leave rather than hang
                    if (is_alarm || son) begin
                        state <= ST_AFTER; // [R16]
                    end else if (off_done) begin
                        state <= ST_AFTER; // [R13]
                    end
                end
                ST_SHORT_STOP, ST_COAST_STOP, ST_REV_STOP: begin
                    if ((slow || brk_done) && state != ST_REV_STOP) begin
                        brake_rel <= 1'b0; // [R15]
                    end
                    // an alarm outranks a reverse brake started for overtravel
                    if (state == ST_REV_STOP && (is_alarm || safe) && method != SM_REV) begin
                        after_hold <= after; // [R18]
                        state <= (method == SM_COAST) ? ST_COAST_STOP : ST_SHORT_STOP;
                    end
                    if (stopped) begin
                        brake_rel <= 1'b0; // [R10]
                        state <= ST_AFTER;
                    end
                end
                ST_AFTER: begin
                    brake_rel <= 1'b0;
                    if (trig) begin
                        after_hold <= after; // follow the strongest trigger [R18]
                    end else begin
                        brake_rel <= 1'b1; // released while servo on
                        state <= ST_RUN;
                    end
                end
                default: state <= ST_AFTER;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // power stage and brake outputs
    // ----------------------------------------------------------------
    // all outputs registered so the power stage sees no decode glitches
    always @(posedge CLK) begin
        if (!RST_B) begin
            MOTOR_POWER_ON <= 1'b0;
            WINDING_SHORT_HOLD <= 1'b0;
            ZERO_SPEED_FORCE <= 1'b0;
            TORQUE_LIMIT <= `SBS_TORQ_RESET;
            ZERO_CLAMP <= 1'b0;
            ALARM_WARNING <= 1'b0;
            BRAKE_RELEASE_OUT <= 3'h0;
        end else begin
            MOTOR_POWER_ON <= state == ST_RUN || state == ST_OFF_WAIT && !is_alarm
                || state == ST_REV_STOP
                || state == ST_AFTER && after_hold == AF_CLAMP; // [R16] [R9]
            WINDING_SHORT_HOLD <= state == ST_SHORT_STOP
                || state == ST_AFTER && after_hold == AF_SHORT; // [R9]
            ZERO_SPEED_FORCE <= (state == ST_REV_STOP); // [R6]
            TORQUE_LIMIT <= (REVERSE_BRAKE_TORQUE_LIMIT > `SBS_TORQ_MAX) ?
                `SBS_TORQ_MAX : REVERSE_BRAKE_TORQUE_LIMIT; // [R7]
            ZERO_CLAMP <= state == ST_AFTER && after_hold == AF_CLAMP; // [R8]
            ALARM_WARNING <= al2 && sel_sec == `SBS_SEC_RUN; // [R5]
            BRAKE_RELEASE_OUT[0] <= brake_rel && !al1
                && OUTPUT_PIN_ALLOCATION[3:0] == `SBS_ALLOC_BRAKE; // [R11]
            BRAKE_RELEASE_OUT[1] <= brake_rel && !al1
                && OUTPUT_PIN_ALLOCATION[7:4] == `SBS_ALLOC_BRAKE; // [R11]
            BRAKE_RELEASE_OUT[2] <= brake_rel && !al1
                && OUTPUT_PIN_ALLOCATION[11:8] == `SBS_ALLOC_BRAKE; // [R11]
        end
    end
endmodule

// *** bench/sbs_props.sv ***
// checker for the stop method and brake sequencer outputs
// assumes it is bound to sbs_top and sees only the ports of that module
module sbs_props (
    input wire CLK,
    input wire RST_B,
    input wire SERVO_ON,
    input wire GROUP_ONE_ALARM,
    input wire [8:0] REVERSE_BRAKE_TORQUE_LIMIT,
    input wire [11:0] OUTPUT_PIN_ALLOCATION,
    input wire [15:0] MOTOR_SPEED_RPM,
    input wire MOTOR_POWER_ON,
    input wire ZERO_SPEED_FORCE,
    input wire [8:0] TORQUE_LIMIT,
    input wire ZERO_CLAMP,
    input wire [2:0] BRAKE_RELEASE_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // ----------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------
    // six cycles covers the two-stage sync plus state and output registers
    sequence s_alarm_held; GROUP_ONE_ALARM [*6]; endsequence
    sequence s_off_still; (!SERVO_ON && MOTOR_SPEED_RPM == 16'h0) [*6]; endsequence
    sequence s_rev_steady; (ZERO_SPEED_FORCE && $stable(REVERSE_BRAKE_TORQUE_LIMIT)) [*3];
    endsequence
    property p_reset_values;
        $rose(RST_B) |-> !MOTOR_POWER_ON && BRAKE_RELEASE_OUT == 3'h0 && TORQUE_LIMIT == 9'h12c;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset outputs wrong");
    property p_torque_max; TORQUE_LIMIT <= 9'h15e; endproperty
    a_torque_max: assert property (p_torque_max) else $error("torque limit above max");
    property p_alarm_stop; s_alarm_held |-> BRAKE_RELEASE_OUT == 3'h0 && !MOTOR_POWER_ON; endproperty
    a_alarm_stop: assert property (p_alarm_stop) else $error("alarm left power or brake");
    property p_off_brake; s_off_still |-> BRAKE_RELEASE_OUT == 3'h0; endproperty
    a_off_brake: assert property (p_off_brake) else $error("brake held off while stopped");
    property p_rev_power; ZERO_SPEED_FORCE |-> MOTOR_POWER_ON; endproperty
    a_rev_power: assert property (p_rev_power) else $error("reverse brake without power");
    property p_clamp_power; ZERO_CLAMP |-> MOTOR_POWER_ON && !ZERO_SPEED_FORCE; endproperty
    a_clamp_power: assert property (p_clamp_power) else $error("clamp without power");
    property p_rev_torque;
        s_rev_steady |-> TORQUE_LIMIT == ((REVERSE_BRAKE_TORQUE_LIMIT > 9'h15e) ?
            9'h15e : REVERSE_BRAKE_TORQUE_LIMIT);
    endproperty
    a_rev_torque: assert property (p_rev_torque) else $error("reverse torque wrong");
    property p_route; BRAKE_RELEASE_OUT[0] |-> $past(OUTPUT_PIN_ALLOCATION[3:0]) == 4'h4;
    endproperty
    a_route: assert property (p_route) else $error("brake on unrouted pin");
endmodule

bind sbs_top sbs_props u_props (.CLK(CLK), .RST_B(RST_B), .SERVO_ON(SERVO_ON),
    .GROUP_ONE_ALARM(GROUP_ONE_ALARM), .REVERSE_BRAKE_TORQUE_LIMIT(REVERSE_BRAKE_TORQUE_LIMIT),
    .OUTPUT_PIN_ALLOCATION(OUTPUT_PIN_ALLOCATION), .MOTOR_SPEED_RPM(MOTOR_SPEED_RPM),
    .MOTOR_POWER_ON(MOTOR_POWER_ON), .ZERO_SPEED_FORCE(ZERO_SPEED_FORCE),
    .TORQUE_LIMIT(TORQUE_LIMIT), .ZERO_CLAMP(ZERO_CLAMP), .BRAKE_RELEASE_OUT(BRAKE_RELEASE_OUT));

// *** bench/sbs_motor_model.sv ***
// motor and load model: shaft speed follows the power stage outputs
// assumes the block clock and speeds in rpm, no direction
module sbs_motor_model (
    input wire clk,
    input wire power_on,
    input wire zero_force,
    input wire short_hold,
    input wire spin,
    output logic [15:0] speed
);
    timeunit 1ns;
    timeprecision 100ps;
    initial speed = 16'h0;
    // ----------------------------------------------------------------
    // speed update
    // ----------------------------------------------------------------
    // shorted windings stop faster than friction alone
    always @(posedge clk) begin
        if (!power_on) begin
            speed <= (speed > 16'h28) ? speed - (short_hold ? 16'h28 : 16'h14) : 16'h0;
        end else if (zero_force) begin
            speed <= (speed > 16'h32) ? speed - 16'h32 : 16'h0;
        end else if (spin) begin
            speed <= 16'h7d0; // reference only after the host waited
        end
    end
endmodule

// *** bench/test_sbs_top.sv ***
// self-checking bench: stop method table, brake timing and routing
// assumes the checker binds itself and a 4-cycle tick for short waits
module test_sbs_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_b = 0, son = 0, g1 = 0, g2 = 0, trv = 0, safe = 0, spin = 0;
    logic [2:0] pri = 0, ots = 0, sec = 0, brk;
    logic [8:0] torq = 9'h12c, offw = 0, tlim;
    logic [6:0] thr = 7'h64, bwait = 7'h32;
    logic [11:0] alloc = 0;
    logic [15:0] rpm;
    logic pwr, dbh, zsf, clamp, warn;
    int fails = 0, n_compared = 0, cycles = 0, seed = 32'h11b7ebbe;
    logic [31:0] q_exp[$];
    event sample_ev;
    string nm[4] = '{"state", "torque", "zero_speed", "brake"};
    // {pri, trv sel, grp2 sel, trig g1 g2 trv safe off, spin, reverse, pwr short clamp warn brk}
    logic [20:0] cases[20] = '{
        {3'h0, 3'h0, 3'h0, 5'h10, 2'h0, 5'h00}, {3'h1, 3'h0, 3'h0, 5'h10, 2'h0, 5'h08},
        {3'h2, 3'h0, 3'h0, 5'h10, 2'h0, 5'h00}, {3'h7, 3'h0, 3'h0, 5'h02, 2'h0, 5'h00},
        {3'h1, 3'h0, 3'h0, 5'h02, 2'h0, 5'h08}, {3'h1, 3'h0, 3'h0, 5'h01, 2'h0, 5'h08},
        {3'h0, 3'h0, 3'h0, 5'h04, 2'h0, 5'h00}, {3'h0, 3'h1, 3'h0, 5'h04, 2'h0, 5'h00},
        {3'h0, 3'h2, 3'h0, 5'h04, 2'h1, 5'h14}, {3'h0, 3'h3, 3'h0, 5'h04, 2'h1, 5'h00},
        {3'h0, 3'h0, 3'h0, 5'h08, 2'h0, 5'h00}, {3'h0, 3'h0, 3'h1, 5'h08, 2'h0, 5'h08},
        {3'h0, 3'h0, 3'h2, 5'h08, 2'h0, 5'h00}, {3'h0, 3'h0, 3'h3, 5'h08, 2'h1, 5'h08},
        {3'h0, 3'h0, 3'h4, 5'h08, 2'h1, 5'h00}, {3'h0, 3'h0, 3'h5, 5'h08, 2'h2, 5'h13},
        {3'h1, 3'h2, 3'h0, 5'h14, 2'h0, 5'h08}, {3'h0, 3'h2, 3'h1, 5'h0c, 2'h0, 5'h08},
        {3'h0, 3'h0, 3'h1, 5'h09, 2'h0, 5'h08}, {3'h0, 3'h2, 3'h0, 5'h05, 2'h1, 5'h14}};
    always #2.5 clk = ~clk;
    sbs_top #(.TICK_CYCLES(4)) DUT (
        .CLK(clk), .RST_B(rst_b), .SERVO_ON(son), .GROUP_ONE_ALARM(g1),
        .GROUP_TWO_ALARM(g2), .TRAVEL_LIMIT_STATE(trv), .SAFETY_STATE(safe),
        .PRIMARY_STOP_SELECT(pri), .OVERTRAVEL_STOP_SELECT(ots),
        .SECONDARY_ALARM_STOP_SELECT(sec), .REVERSE_BRAKE_TORQUE_LIMIT(torq),
        .SERVO_OFF_WAIT_TIME(offw), .BRAKE_SPEED_THRESHOLD(thr), .BRAKE_WAIT_TIME(bwait),
        .OUTPUT_PIN_ALLOCATION(alloc), .MOTOR_SPEED_RPM(rpm), .MOTOR_POWER_ON(pwr),
        .WINDING_SHORT_HOLD(dbh), .ZERO_SPEED_FORCE(zsf), .TORQUE_LIMIT(tlim),
        .ZERO_CLAMP(clamp), .ALARM_WARNING(warn), .BRAKE_RELEASE_OUT(brk));
    sbs_motor_model motor (.clk(clk), .power_on(pwr), .zero_force(zsf), .short_hold(dbh),
        .spin(spin), .speed(rpm));
    // ----------------------------------------------------------------
    // scoreboard and closing
    // ----------------------------------------------------------------
    function automatic logic [15:0] seen(input logic [3:0] k);
        case (k)
            4'h0: seen = {11'h0, pwr, dbh, clamp, warn, |brk};
            4'h1: seen = {7'h0, tlim};
            4'h2: seen = {15'h0, zsf};
            default: seen = {13'h0, brk};
        endcase
    endfunction
    // the monitor drains every note queued since its last wake-up
    always @(sample_ev) begin
        logic [31:0] e;
        while (q_exp.size() > 0) begin
            e = q_exp.pop_front();
            n_compared++;
            if (seen(e[19:16]) !== e[15:0]) begin
                fails++;
                $display("CHECK FAILED %s exp %h seen %h", nm[e[17:16]], e[15:0], seen(e[19:16]));
            end
        end
    end
    task automatic give_verdict;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // a hung wait counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic note(input logic [3:0] k, input logic [15:0] v);
        q_exp.push_back({12'h0, k, v});
        -> sample_ev;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // selectors only count while reset is held
    task automatic restart(input logic [2:0] p, input logic [2:0] o, input logic [2:0] s);
        rst_b = 0;
        {pri, ots, sec} = {p, o, s};
        {son, g1, g2, trv, safe, spin} = 6'h0;
        wait_cyc(4);
        rst_b = 1;
        alloc = 12'h004;
        son = 1;
        wait_cyc(20); // host waits before any reference
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [20:0] c;
        logic [2:0] mask;
        wait_cyc(16); // restart adds four more, so reset stands 20 cycles
        foreach (cases[i]) begin
            c = cases[i];
            restart(c[20:18], c[17:15], c[14:12]);
            alloc = {($random(seed) & 1) ? 4'h4 : 4'h5, ($random(seed) & 1) ? 4'h4 : 4'h0, 4'h4};
            torq = 9'($random(seed));
            mask = {alloc[11:8] == 4'h4, alloc[7:4] == 4'h4, 1'b1};
            spin = 1;
            wait_cyc(10);
            note(4'h3, {13'h0, mask});
            note(4'h0, 16'h11);
            {g1, g2, trv, safe} = c[11:8];
            son = !c[7];
            spin = c[6];
            wait_cyc(10);
            note(4'h2, {15'h0, c[5]});
            if (c[5]) note(4'h1, {7'h0, (torq > 9'h15e) ? 9'h15e : torq});
            wait_cyc(300);
            note(4'h0, {11'h0, c[4:0]});
        end
        // stopped servo-off: brake at once, power after three ticks
        restart(3'h0, 3'h0, 3'h0);
        offw = 9'h3;
        son = 0;
        wait_cyc(6);
        note(4'h0, 16'h10);
        wait_cyc(20);
        note(4'h0, 16'h0);
        // alarm ignores a long servo-off wait
        restart(3'h0, 3'h0, 3'h0);
        offw = 9'h1f4;
        g1 = 1;
        wait_cyc(6);
        note(4'h0, 16'h0);
        // running coast stop: brake by wait time before speed is low
        restart(3'h2, 3'h0, 3'h0);
        {thr, bwait, spin} = {7'h0a, 7'h0a, 1'b1};
        wait_cyc(10);
        {son, spin} = 2'h0;
        wait_cyc(30);
        note(4'h3, 16'h1);
        wait_cyc(30);
        note(4'h3, 16'h0);
        wait_cyc(2);
        give_verdict();
    end
endmodule
